// ==== ipr_pkg.sv ====
// Constants, types and helpers for the indirect phy register port
// Behaviour
// - The 30-bit target index selects the phy register behind the data port.
// - Direction select 0 means read, 1 means write of the selected register.
// - Done flag reads 0 while an access runs, 1 when idle.
// - Indices 00h-07h name channel A registers; channel B adds 20h.
// - Receiver-enable sets sit at 10h,13h,16h,19h (B: +20h); others reserved.
// - Package strap moves receiver-enable set 0 to chip-select lines 3 and 2.
// - On writes, done rises only after the phy register really holds the data.
// - Data port is 32-bit read/write, resets to zero, carries selected register.
// - Drive compensation holds termination, strobe and data strength fields.
// - Drive compensation holds clock, addr/cmd, chipsel and clock-enable strengths.
// - Done flag is 1 after reset.
// - Memory clock is driven only once frequency valid is set.
package ipr_pkg;

  // APB byte addresses
  localparam logic [7:0] ADDR_CLK_CFG = 8'h94;
  localparam logic [7:0] ADDR_INDEX   = 8'h98;
  localparam logic [7:0] ADDR_DATA    = 8'h9C;

  // Index/control field positions
  localparam int DONE_BIT   = 31;
  localparam int DIR_BIT    = 30;
  localparam int INDEX_MSB  = 29;
  localparam int FREQ_VALID_BIT = 3;
  localparam int FREQ_MSB   = 2;

  // Reset values
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  localparam logic [29:0] INDEX_RESET = 30'h0000_0000;
  localparam logic        DONE_RESET  = 1'b1;
  localparam logic [2:0]  FREQ_RESET  = 3'h0;

  // Index map
  localparam logic [4:0] IDX_DRV_COMP   = 5'h00;
  localparam logic [4:0] IDX_LAST_TIME  = 5'h07;
  localparam logic [4:0] IDX_RCV_EN0    = 5'h10;
  localparam logic [4:0] IDX_RCV_EN1    = 5'h13;
  localparam logic [4:0] IDX_RCV_EN2    = 5'h16;
  localparam logic [4:0] IDX_RCV_EN3    = 5'h19;
  localparam int         CHAN_B_BIT     = 5;
  localparam int         PHY_ADDR_W     = 6;

  // Drive compensation field positions (each field two bits wide)
  localparam int TERM_SEL_LSB   = 28;
  localparam int STROBE_DRV_LSB = 20;
  localparam int DATA_DRV_LSB   = 16;
  localparam int CLK_DRV_LSB    = 12;
  localparam int ADDR_DRV_LSB   = 8;
  localparam int CS_DRV_LSB     = 4;
  localparam int CKE_DRV_LSB    = 0;

  localparam logic [31:0] DRV_COMP_MASK =
    (32'h3 << TERM_SEL_LSB) | (32'h3 << STROBE_DRV_LSB) | (32'h3 << DATA_DRV_LSB) |
    (32'h3 << CLK_DRV_LSB) | (32'h3 << ADDR_DRV_LSB) | (32'h3 << CS_DRV_LSB) |
    (32'h3 << CKE_DRV_LSB);
  localparam logic [31:0] DRV_COMP_RESET =
    (32'h1 << STROBE_DRV_LSB) | (32'h1 << DATA_DRV_LSB) | (32'h1 << CLK_DRV_LSB) |
    (32'h2 << ADDR_DRV_LSB) | (32'h2 << CS_DRV_LSB) | (32'h2 << CKE_DRV_LSB);

  // Chip-select base of receiver-enable set 0, normal and strapped package
  localparam logic [1:0] RCV_EN0_CS_NORMAL = 2'h0;
  localparam logic [1:0] RCV_EN0_CS_ALT    = 2'h2;

  typedef enum logic [1:0] {TGT_NONE, TGT_DRV_COMP, TGT_PHY} ipr_target_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FINISH} ipr_state_t;

  // Classify a target index; anything outside the map is reserved
  function automatic ipr_target_t ipr_decode(input logic [29:0] idx);
    logic [4:0] low;
    low = idx[4:0];
    if (idx[29:6] != 24'h00_0000)
      return TGT_NONE;
    if (low == IDX_DRV_COMP)
      return TGT_DRV_COMP;
    if (low <= IDX_LAST_TIME)
      return TGT_PHY;
    if (low == IDX_RCV_EN0 || low == IDX_RCV_EN1 || low == IDX_RCV_EN2 || low == IDX_RCV_EN3)
      return TGT_PHY;
    return TGT_NONE;
  endfunction

endpackage

// ==== ipr_phy_if.sv ====
// Request/answer bundle between the port logic and the phy register store
`timescale 1ns/1ps
`default_nettype none
interface ipr_phy_if;
  logic                          req;
  logic                          wr;
  logic [ipr_pkg::PHY_ADDR_W-1:0] addr;
  logic [31:0]                   wdata;
  logic [31:0]                   rdata;

  modport port (output req, output wr, output addr, output wdata, input rdata);
  modport store (input req, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== ipr_phy_mem.sv ====
// Phy timing register store, 64 words, registered read data
`timescale 1ns/1ps
`default_nettype none
module ipr_phy_mem (
  // Clock and control
  input  wire logic  clk,
  input  wire logic  ce,
  // Access bundle
  ipr_phy_if.store   bus
);
  logic [31:0] mem [0:(1 << ipr_pkg::PHY_ADDR_W)-1];
  logic [31:0] rdataReg;

  // Contents carry no reset; only the port's index map defines them
  always_ff @(posedge clk) begin
    if (ce && bus.req) begin
      if (bus.wr) begin
        mem[bus.addr] <= bus.wdata;
      end else begin
        rdataReg <= mem[bus.addr];
      end
    end
  end

  assign bus.rdata = rdataReg;
endmodule
`default_nettype wire

// ==== ipr_top.sv ====
// APB slave for the indirect phy register index/data port
`timescale 1ns/1ps
`default_nettype none
module ipr_top (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Package strap
  input  wire logic        altPackage,
  // Phy controls
  output logic [31:0]      driveCompA,
  output logic [31:0]      driveCompB,
  output logic             memClkEnable,
  output logic [2:0]       memClkFreqSel,
  output logic [1:0]       rcvEnSet0CsBase,
  output logic             accessBusy
);

  // Register state
  logic [29:0]          targetIndex_reg;
  logic [29:0]          targetIndex_next;
  logic                 directionSelect_reg;
  logic                 directionSelect_next;
  logic                 accessDoneFlag_reg;
  logic                 accessDoneFlag_next;
  logic [31:0]          indirectDataWord_reg;
  logic [31:0]          indirectDataWord_next;
  logic [31:0]          driveCompA_reg;
  logic [31:0]          driveCompA_next;
  logic [31:0]          driveCompB_reg;
  logic [31:0]          driveCompB_next;
  logic                 memoryClockFreqValid_reg;
  logic [2:0]           memClkFreq_reg;
  logic                 strapTaken_reg;
  logic                 altPackage_reg;
  logic [31:0]          prdata_reg;
  logic                 pslverr_reg;
  ipr_pkg::ipr_state_t  state_reg;
  ipr_pkg::ipr_state_t  state_next;

  // Bus decode
  wire logic setupPhase;
  wire logic accessPhase;
  wire logic hitClkCfg;
  wire logic hitIndex;
  wire logic hitData;
  wire logic fullWord;
  wire logic writeIndex;
  wire logic writeData;
  wire logic writeClkCfg;
  wire logic badAccess;
  wire logic idle;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable && ce;
  assign hitClkCfg   = paddr == ipr_pkg::ADDR_CLK_CFG;
  assign hitIndex    = paddr == ipr_pkg::ADDR_INDEX;
  assign hitData     = paddr == ipr_pkg::ADDR_DATA;
  assign fullWord    = pstrb == 4'hF;
  assign idle        = state_reg == ipr_pkg::ST_IDLE;

  // Index and data writes while an access runs are dropped so the running one stays intact
  assign writeIndex  = accessPhase && pwrite && hitIndex && idle;
  // Partial writes to the data port are refused outright
  assign writeData   = accessPhase && pwrite && hitData && fullWord && idle;
  assign writeClkCfg = accessPhase && pwrite && hitClkCfg;
  assign badAccess   = !(hitClkCfg || hitIndex || hitData) ||
                       (pwrite && hitData && !fullWord);

  // No wait states; a frozen block also holds the bus
  assign pready  = ce;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Target decode of the latched index
  ipr_pkg::ipr_target_t target;
  wire logic            chanB;

  assign target = ipr_pkg::ipr_decode(targetIndex_reg);
  assign chanB  = targetIndex_reg[ipr_pkg::CHAN_B_BIT];

  // Phy store
  ipr_phy_if phyBus ();

  ipr_phy_mem i_ipr_phy_mem (
    .clk (clk),
    .ce  (ce),
    .bus (phyBus.store)
  );

  // Store request only in the issue cycle and only for mapped phy slots
  assign phyBus.req   = state_reg == ipr_pkg::ST_ISSUE && target == ipr_pkg::TGT_PHY;
  assign phyBus.wr    = directionSelect_reg;
  assign phyBus.addr  = targetIndex_reg[ipr_pkg::PHY_ADDR_W-1:0];
  assign phyBus.wdata = indirectDataWord_reg;

  // Sequencer: idle, issue to the selected register, finish
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ipr_pkg::ST_IDLE: begin
        if (writeIndex) begin
          state_next = ipr_pkg::ST_ISSUE;
        end
      end
      ipr_pkg::ST_ISSUE: begin
        state_next = ipr_pkg::ST_FINISH;
      end
      ipr_pkg::ST_FINISH: begin
        state_next = ipr_pkg::ST_IDLE;
      end
      default: begin
        state_next = ipr_pkg::ST_IDLE;
      end
    endcase
  end

  // Index, direction and done flag
  always_comb begin
    targetIndex_next     = targetIndex_reg;
    directionSelect_next = directionSelect_reg;
    accessDoneFlag_next  = accessDoneFlag_reg;
    if (writeIndex) begin
      targetIndex_next     = pwdata[ipr_pkg::INDEX_MSB:0];
      directionSelect_next = pwdata[ipr_pkg::DIR_BIT];
      accessDoneFlag_next  = 1'b0;
    end
    // Only reached a cycle after the write landed in the target
    if (state_reg == ipr_pkg::ST_FINISH) begin
      accessDoneFlag_next = 1'b1;
    end
  end

  // Data port: software writes when idle, phy reads land at finish
  always_comb begin
    indirectDataWord_next = indirectDataWord_reg;
    if (writeData) begin
      indirectDataWord_next = pwdata;
    end
    if (state_reg == ipr_pkg::ST_FINISH && !directionSelect_reg) begin
      unique case (target)
        ipr_pkg::TGT_DRV_COMP:
          indirectDataWord_next = chanB ? driveCompB_reg : driveCompA_reg;
        ipr_pkg::TGT_PHY:
          indirectDataWord_next = phyBus.rdata;
        default:
          indirectDataWord_next = 32'h0000_0000; // reserved index reads zero
      endcase
    end
  end

  // Drive compensation, one per channel; reserved bits never stored
  wire logic writeComp;

  assign writeComp = state_reg == ipr_pkg::ST_ISSUE && directionSelect_reg &&
                     target == ipr_pkg::TGT_DRV_COMP;

  always_comb begin
    driveCompA_next = driveCompA_reg;
    driveCompB_next = driveCompB_reg;
    if (writeComp && !chanB) begin
      driveCompA_next = indirectDataWord_reg & ipr_pkg::DRV_COMP_MASK;
    end
    if (writeComp && chanB) begin
      driveCompB_next = indirectDataWord_reg & ipr_pkg::DRV_COMP_MASK;
    end
  end

  // Read mux for the setup-phase capture
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h0000_0000;
    if (hitIndex) begin
      readMux = {accessDoneFlag_reg, directionSelect_reg, targetIndex_reg};
    end else if (hitData) begin
      readMux = indirectDataWord_reg;
    end else if (hitClkCfg) begin
      readMux[ipr_pkg::FREQ_VALID_BIT] = memoryClockFreqValid_reg;
      readMux[ipr_pkg::FREQ_MSB:0]     = memClkFreq_reg;
    end
  end

  // Sequencer and port registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg           <= ipr_pkg::ST_IDLE;
      targetIndex_reg     <= ipr_pkg::INDEX_RESET;
      directionSelect_reg <= 1'b0;
      accessDoneFlag_reg  <= ipr_pkg::DONE_RESET;
    end else if (ce) begin
      state_reg           <= state_next;
      targetIndex_reg     <= targetIndex_next;
      directionSelect_reg <= directionSelect_next;
      accessDoneFlag_reg  <= accessDoneFlag_next;
    end
  end

  // Data port and compensation registers
  always_ff @(posedge clk) begin
    if (reset) begin
      indirectDataWord_reg <= ipr_pkg::DATA_RESET;
      driveCompA_reg       <= ipr_pkg::DRV_COMP_RESET;
      driveCompB_reg       <= ipr_pkg::DRV_COMP_RESET;
    end else if (ce) begin
      indirectDataWord_reg <= indirectDataWord_next;
      driveCompA_reg       <= driveCompA_next;
      driveCompB_reg       <= driveCompB_next;
    end
  end

  // Clock configuration; the clock stays off until marked valid
  always_ff @(posedge clk) begin
    if (reset) begin
      memoryClockFreqValid_reg <= 1'b0;
      memClkFreq_reg           <= ipr_pkg::FREQ_RESET;
    end else if (writeClkCfg) begin
      memoryClockFreqValid_reg <= pwdata[ipr_pkg::FREQ_VALID_BIT];
      memClkFreq_reg           <= pwdata[ipr_pkg::FREQ_MSB:0];
    end
  end

  // Read data and error captured in setup so the access phase shows flops
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce && setupPhase) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : readMux;
      pslverr_reg <= badAccess;
    end
  end

  // Strap taken once after reset release, never under reset
  always_ff @(posedge clk) begin
    if (reset) begin
      strapTaken_reg <= 1'b0;
      altPackage_reg <= 1'b0;
    end else if (ce && !strapTaken_reg) begin
      strapTaken_reg <= 1'b1;
      altPackage_reg <= altPackage;
    end
  end

  // Outputs
  assign driveCompA      = driveCompA_reg;
  assign driveCompB      = driveCompB_reg;
  assign memClkEnable    = memoryClockFreqValid_reg;
  assign memClkFreqSel   = memClkFreq_reg;
  assign rcvEnSet0CsBase = altPackage_reg ? ipr_pkg::RCV_EN0_CS_ALT
                                          : ipr_pkg::RCV_EN0_CS_NORMAL;
  assign accessBusy      = !accessDoneFlag_reg;

endmodule
`default_nettype wire

// ==== ipr_top_sva.sv ====
// Port assertions for the indirect phy register port
`timescale 1ns/1ps
`default_nettype none
module ipr_top_sva (
  // Clock, reset, APB
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Strap and phy controls
  input wire logic        altPackage,
  input wire logic [31:0] driveCompA,
  input wire logic        memClkEnable,
  input wire logic [1:0]  rcvEnSet0CsBase,
  input wire logic        accessBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Decoded bus phases
  wire logic setup   = psel && !penable && ce;
  wire logic acc     = psel && penable && ce;
  wire logic ixW     = acc && pwrite && paddr == ipr_pkg::ADDR_INDEX && !accessBusy;
  wire logic freqBit = pwdata[ipr_pkg::FREQ_VALID_BIT];
  // Index write followed by two live cycles
  sequence runS;
    ixW ##1 ce ##1 ce;
  endsequence
  readyCe_a: assert property (pready == ce) else $error("pready differs from ce");
  busyStart_a: assert property (ixW |=> accessBusy) else $error("busy not raised");
  doneRise_a: assert property (runS |-> ##[0:1] !accessBusy) else $error("done late");
  resetVal_a: assert property ($fell(reset) |-> driveCompA == 32'h0011_1222
    && !accessBusy && !memClkEnable) else $error("bad reset value");
  rsvZero_a: assert property ((driveCompA & 32'hCFCC_CCCC) == 32'h0)
    else $error("reserved bit set");
  clkEn_a: assert property (acc && pwrite && paddr == ipr_pkg::ADDR_CLK_CFG
    |=> memClkEnable == $past(freqBit)) else $error("clock enable wrong");
  strbErr_a: assert property (setup && pwrite && paddr == ipr_pkg::ADDR_DATA
    && pstrb != 4'hF && !accessBusy |=> pslverr) else $error("no strobe error");
  doneRead_a: assert property (setup && !pwrite && paddr == ipr_pkg::ADDR_INDEX
    |=> prdata[31] == !$past(accessBusy)) else $error("done read wrong");
  strap_a: assert property ($fell(reset) && ce
    |=> rcvEnSet0CsBase == ($past(altPackage) ? 2'h2 : 2'h0)) else $error("strap wrong");
endmodule
`default_nettype wire

// ==== ipr_top_test.sv ====
// Self-checking bench for the indirect phy register port
`timescale 1ns/1ps
`default_nettype none
module ipr_top_test;
  logic        clk, reset, ce, psel, penable, pwrite, altPackage, pready, pslverr, err;
  logic        memClkEnable, accessBusy;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [2:0]  memClkFreqSel;
  logic [1:0]  rcvEnSet0CsBase;
  logic [29:0] idx;
  logic [31:0] pwdata, prdata, driveCompA, driveCompB, rd, lfsrState, expD, expA;
  int          miscompares = 0;
  int          nCompared = 0;
  int          cycles = 0;
  logic [29:0] idxTab [0:16] = '{30'h01, 30'h02, 30'h03, 30'h04, 30'h05, 30'h06, 30'h07,
    30'h10, 30'h13, 30'h16, 30'h19, 30'h08, 30'h11, 30'h12, 30'h1A, 30'h1B, 30'h40};

  ipr_top i_ipr_top (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .altPackage(altPackage), .driveCompA(driveCompA),
    .driveCompB(driveCompB), .memClkEnable(memClkEnable), .memClkFreqSel(memClkFreqSel),
    .rcvEnSet0CsBase(rcvEnSet0CsBase), .accessBusy(accessBusy));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finishTest();
    end
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reserved slots read back zero, mapped slots keep the word
  function automatic logic [31:0] expPhy(input logic [29:0] ix, input logic [31:0] d);
    logic [4:0] lo;
    lo = ix[4:0];
    if (ix[29:6] == 24'h0 && (lo <= 5'h07 || lo == 5'h10 || lo == 5'h13 || lo == 5'h16
        || lo == 5'h19))
      return d;
    return 32'h0;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count assumed; the hang guard ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll done; the first poll still sees the access running, the second sees it over
  task automatic waitDone();
    int n;
    logic firstDone;
    n = 0;
    firstDone = 1'b1;
    rd = 32'h0;
    while (rd[31] !== 1'b1) begin
      apb(ipr_pkg::ADDR_INDEX, 1'b0, 32'h0, 4'hF);
      if (n == 0)
        firstDone = rd[31];
      n++;
    end
    check("done at first poll", 32'h0, {31'h0, firstDone});
    check("done poll count", 32'h2, n);
  endtask

  task automatic phyWrite(input logic [29:0] ix, input logic [31:0] d);
    apb(ipr_pkg::ADDR_DATA, 1'b1, d, 4'hF);
    apb(ipr_pkg::ADDR_INDEX, 1'b1, {2'b01, ix}, 4'hF);
    waitDone();
  endtask

  task automatic phyRead(input logic [29:0] ix);
    apb(ipr_pkg::ADDR_INDEX, 1'b1, {2'b00, ix}, 4'hF);
    waitDone();
    apb(ipr_pkg::ADDR_DATA, 1'b0, 32'h0, 4'hF);
  endtask

  // Outputs and registers right after a reset release
  task automatic resetChecks();
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("drive comp A", 32'h0011_1222, driveCompA);
    check("drive comp B", 32'h0011_1222, driveCompB);
    check("strap base", {30'h0, altPackage, 1'b0}, {30'h0, rcvEnSet0CsBase});
    check("clock enable off", 32'h0, {31'h0, memClkEnable});
    apb(ipr_pkg::ADDR_INDEX, 1'b0, 32'h0, 4'hF);
    check("index reset", 32'h8000_0000, rd);
    apb(ipr_pkg::ADDR_DATA, 1'b0, 32'h0, 4'hF);
    check("data reset", 32'h0, rd);
  endtask

  task automatic finishTest();
    $display("Compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    lfsrState = 32'h879B42DB;
    altPackage = lfsrState[0];
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    resetChecks();
    apb(8'h90, 1'b0, 32'h0, 4'hF);
    check("unmapped error", 32'h1, {31'h0, err});
    lfsrState = lfsrNext(lfsrState);
    apb(ipr_pkg::ADDR_CLK_CFG, 1'b1, {28'h0, 1'b1, lfsrState[2:0]}, 4'hF);
    @(negedge clk);
    check("clock enable", 32'h1, {31'h0, memClkEnable});
    check("freq select", 32'(lfsrState[2:0]), 32'(memClkFreqSel));
    phyRead(30'h20);
    check("comp via port", 32'h0011_1222, rd);
    // Drive compensation on both channels, random words
    for (int i = 0; i < 8; i++) begin
      lfsrState = lfsrNext(lfsrState);
      expD = lfsrState & 32'h3033_3333;
      if (!i[0])
        expA = expD;
      phyWrite({24'h0, i[0], 5'h0}, lfsrState);
      check("comp output", expD, i[0] ? driveCompB : driveCompA);
      phyRead({24'h0, i[0], 5'h0});
      check("comp readback", expD, rd);
    end
    apb(ipr_pkg::ADDR_DATA, 1'b1, ~expD, 4'h3);
    check("strobe error", 32'h1, {31'h0, err});
    apb(ipr_pkg::ADDR_DATA, 1'b0, 32'h0, 4'hF);
    check("data kept", expD, rd);
    // Timing slots and reserved holes, both channels
    for (int i = 0; i < 34; i++) begin
      idx = idxTab[i % 17] | (i >= 17 ? 30'h20 : 30'h0);
      lfsrState = lfsrNext(lfsrState);
      phyWrite(idx, lfsrState);
      phyRead(idx);
      check("phy slot", expPhy(idx, lfsrState), rd);
    end
    // Freeze with ce low in mid-access; busy must hold
    apb(ipr_pkg::ADDR_INDEX, 1'b1, 32'h0, 4'hF);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("busy frozen", 32'h1, {31'h0, accessBusy});
    check("ready low", 32'h0, {31'h0, pready});
    @(posedge clk);
    ce <= 1'b1;
    waitDone();
    apb(ipr_pkg::ADDR_DATA, 1'b0, 32'h0, 4'hF);
    check("frozen read", expA, rd);
    // Second reset in mid-run, strap flipped so both package values are seen
    @(posedge clk);
    reset <= 1'b1;
    altPackage <= ~altPackage;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    resetChecks();
    finishTest();
  end
endmodule

bind ipr_top ipr_top_sva i_ipr_top_sva (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .altPackage(altPackage),
  .driveCompA(driveCompA), .memClkEnable(memClkEnable),
  .rcvEnSet0CsBase(rcvEnSet0CsBase), .accessBusy(accessBusy));
`default_nettype wire
